// file: verilog/servo_status_code_reporter.sv
//
// Summary of operation
// - Drive an 8-bit two-digit status code, re-scanned while powered.
// - After seek or power-on success, show upper eight destination bits.
// - Hold destination until a new seek starts or an error arrives.
// - Error code gives type and step; held until its clearing action.
// - Raise on-track only after successful seek, telling success apart.
// - Normal stop shows 01 unloading, 02 braking, 03 stopped and unlocked.
// - Normal start shows 04 to 08 for interlock checks and start progress.
// - Spin-up faults show codes 09 through 0F.
// - Speed-drop restart shows 10, and 11 to 1F as stop/start codes.
// - Head load faults show 20 to 27; retry-limit faults show 28 to 2D.
// - Return-to-zero seek failures show codes 30 to 39.
// - Guard band hits show 40 to 42 inner, 43 to 45 outer.
// - Seek timeout shows 46; on-track routine failures show 47 to 4A.
// - 4B off-track, 4C lost demod, 4E volts; 4D for cylinder over 822.
// - Reset recovery 50-53, 5B many fan faults, 5C to 5F other faults.
// - Show 80 for fault before seek, 90 after spindle speed recovery.
// - A prior fault lifts load, zero-seek, guard, track codes to A-C.
// - Show FF when the processor fails its power-on self-test.
// - After 08, show 00 once heads reach cylinder 0 without error.
//
`timescale 1ns/1ps
`default_nettype none
`include "status_defs.svh"

module servo_status_code_reporter
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset,
    // Sequence progress
    input  wire status_pkg::phase_e     phase,
    input  wire logic                   heads_unloading,
    input  wire logic                   motor_braking,
    input  wire logic                   motor_stopped,
    input  wire logic                   start_in_progress,
    input  wire logic                   speed_recovery,
    // Seek request and completion
    input  wire logic                   seek_start,
    input  wire logic [`CYL_WIDTH-1:0]  seek_cylinder,
    input  wire logic                   seek_done,
    input  wire logic                   at_cylinder_zero,
    // Fault reporting
    input  wire logic                   fault_valid,
    input  wire logic [3:0]             fault_index,
    input  wire logic                   fault_retry_limit,
    input  wire logic                   fault_prior,
    input  wire status_pkg::guard_ctx_e guard_ctx,
    input  wire logic                   guard_outer,
    input  wire logic                   fault_before_seek,
    input  wire logic                   speed_loss_recovered,
    input  wire logic                   fan_fault,
    input  wire logic                   self_test_fail,
    input  wire logic                   error_clear,
    // Test jack to the status_display_board
    output logic [7:0]                  status_code,
    output logic                        on_track
);
    import status_pkg::*;

    logic             tick;
    logic             fan_many;
    logic             fan_clear;
    rep_state_e       state_ff;
    code_t            code_ff;
    code_t            nxt_code;
    logic             nxt_is_error;
    logic             on_track_ff;
    logic             self_fail_ff;
    logic             start_seen_ff;
    code_t            pend_err_ff;
    logic             pend_valid_ff;
    code_t            fault_code;
    logic [`CYL_WIDTH-1:0] dest_ff;
    logic             bad_cyl;
    code_t            progress_code;

    // The checks at the end all share this clock and reset.
    default clocking chk_cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    scan_tick u_tick
    (
        .clock (clock),
        .reset (reset),
        .tick  (tick)
    );

    assign fan_clear = error_clear;

    fan_counter u_fan
    (
        .clock     (clock),
        .reset     (reset),
        .fan_fault (fan_fault),
        .clear     (fan_clear),
        .too_many  (fan_many)
    );

    assign bad_cyl = seek_start && (seek_cylinder > `CYL_MAX);

    // ------------------------------------------------------------------
    // Fault code encoding
    // ------------------------------------------------------------------
    // Maps the reported fault to a code by phase. A prior fault lifts
    // load, zero-seek, guard and track codes by 80 hex, giving A to C.
    always_comb
    begin
        fault_code = `CODE_ZERO;
        case (phase)
            phase_start:
            begin
                // Spin-up faults 09..0F, plus the speed-drop bias.
                fault_code = `CODE_SPIN_BASE + code_t'(fault_index);
                if (fault_code > `CODE_SPIN_LAST)
                    fault_code = `CODE_SPIN_LAST;
                if (speed_recovery)
                    fault_code = fault_code + `CODE_RECOVERY_BIAS;
            end
            phase_load:
            begin
                if (fault_retry_limit &&
                    fault_index >= 4'(`CODE_RETRY_FIRST - `CODE_LOAD_BASE))
                    fault_code = `CODE_LOAD_RETRY + code_t'(fault_index)
                               - (`CODE_RETRY_FIRST - `CODE_LOAD_BASE);
                else
                    fault_code = `CODE_LOAD_BASE + code_t'(fault_index[2:0]);
            end
            phase_rtz:
                fault_code = `CODE_RTZ_BASE + code_t'(fault_index);
            phase_seek:
                fault_code = `CODE_SEEK_TIMEOUT;
            phase_on_track:
            begin
                // Index 0..3 routine failures, 4.. steady faults.
                if (fault_index < 4'h4)
                    fault_code = `CODE_ONTRK_BASE + code_t'(fault_index);
                else if (fault_index == 4'h4)
                    fault_code = `CODE_OFF_TRACK;
                else if (fault_index == 4'h5)
                    fault_code = `CODE_LOST_DEMOD;
                else
                    fault_code = `CODE_VOLT_FAULT;
            end
            phase_reset_recov:
            begin
                if (fault_index < 4'h4)
                    fault_code = `CODE_RESET_BASE + code_t'(fault_index);
                else if (fault_index == 4'h4)
                    fault_code = `CODE_FIRST_SEEK;
                else if (fault_index == 4'h5)
                    fault_code = `CODE_DEMOD_UNLOAD;
                else
                    fault_code = `CODE_ADAPTER;
            end
            default:
                fault_code = `CODE_SPEED_LOSS;
        endcase
        // Guard band hits override the phase decode.
        if (phase == phase_seek && fault_index != 4'h0 ||
            phase == phase_on_track && fault_index > 4'h6)
        begin
            fault_code = `CODE_GUARD_BASE + code_t'(guard_ctx)
                       + (guard_outer ? 8'h03 : 8'h00);
        end
        if (fault_prior && (phase == phase_load || phase == phase_rtz ||
            phase == phase_seek || phase == phase_on_track))
            fault_code = fault_code + `CODE_PRE_BIAS;
    end

    // ------------------------------------------------------------------
    // Progress code
    // ------------------------------------------------------------------
    // Stop and start progress; the speed-drop restart adds 10 hex.
    always_comb
    begin
        progress_code = `CODE_ZERO;
        if (heads_unloading)
            progress_code = `CODE_UNLOAD;
        else if (motor_braking)
            progress_code = `CODE_BRAKE;
        else if (motor_stopped)
            progress_code = `CODE_STOPPED;
        else if (start_in_progress)
            progress_code = `CODE_STARTING;
        if (speed_recovery && progress_code != `CODE_ZERO)
            progress_code = progress_code + `CODE_RECOVERY_BIAS;
    end

    // ------------------------------------------------------------------
    // Next committed code
    // ------------------------------------------------------------------
    // Priority: self-test, bad address, fault events, then progress.
    // Interlock faults 04..07 arrive as fault_index in phase_idle with
    // fault_valid; those are decoded in the pending error capture in the start family.
    always_comb
    begin
        nxt_code = code_ff;
        nxt_is_error = 1'b0;
        if (self_fail_ff)
        begin
            nxt_code = `CODE_SELF_TEST;
            nxt_is_error = 1'b1;
        end
        else if (pend_valid_ff)
        begin
            nxt_code = pend_err_ff;
            nxt_is_error = 1'b1;
        end
        else if (state_ff == rep_progress)
            nxt_code = progress_code;
    end

    // ------------------------------------------------------------------
    // Pending error capture
    // ------------------------------------------------------------------
    // Errors are caught the cycle they occur and wait for the next
    // scan tick, so no event slips between two evaluations.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pend_err_ff <= `CODE_ZERO;
            pend_valid_ff <= 1'b0;
        end
        else if (bad_cyl)
        begin
            pend_err_ff <= fault_prior ? `CODE_BAD_CYL + `CODE_PRE_BIAS
                                      : `CODE_BAD_CYL;
            pend_valid_ff <= 1'b1;
        end
        else if (fault_before_seek)
        begin
            pend_err_ff <= `CODE_PRE_FAULT;
            pend_valid_ff <= 1'b1;
        end
        else if (fan_many)
        begin
            pend_err_ff <= `CODE_FAN_MANY;
            pend_valid_ff <= 1'b1;
        end
        else if (fan_fault)
        begin
            pend_err_ff <= `CODE_FAN;
            pend_valid_ff <= 1'b1;
        end
        else if (fault_valid)
        begin
            pend_err_ff <= (phase == phase_idle && fault_index <= 4'h3)
                         ? `CODE_NO_PACK + code_t'(fault_index)
                         : fault_code;
            pend_valid_ff <= 1'b1;
        end
        else if (speed_loss_recovered)
        begin
            pend_err_ff <= `CODE_SPEED_RECOV;
            pend_valid_ff <= 1'b1;
        end
        else if (tick)
            pend_valid_ff <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Self-test failure latch
    // ------------------------------------------------------------------
    // Sticky until reset; a failed processor cannot clear itself.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            self_fail_ff <= 1'b0;
        else if (self_test_fail)
            self_fail_ff <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Destination register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            dest_ff <= '0;
        else if (seek_start && !bad_cyl)
            dest_ff <= seek_cylinder;
    end

    // ------------------------------------------------------------------
    // Start tracking for the cylinder-zero report
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            start_seen_ff <= 1'b0;
        else if (start_in_progress)
            start_seen_ff <= 1'b1;
        else if (state_ff != rep_progress)
            start_seen_ff <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Reporter state
    // ------------------------------------------------------------------
    // Errors dominate; only error_clear releases them. A new error in
    // the clear cycle wins, since it is pending until the next tick.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            state_ff <= rep_progress;
        else
        begin
            case (state_ff)
                rep_progress:
                    if (tick && nxt_is_error)
                        state_ff <= rep_error;
                    else if (seek_done || (start_seen_ff && at_cylinder_zero))
                        state_ff <= rep_destination;
                rep_destination:
                    if (tick && nxt_is_error)
                        state_ff <= rep_error;
                    else if (seek_start)
                        state_ff <= rep_progress;
                rep_error:
                    if (error_clear && !pend_valid_ff && !self_fail_ff)
                        state_ff <= rep_progress;
                default:
                    state_ff <= rep_progress;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Committed code and on-track flag
    // ------------------------------------------------------------------
    // Updated on scan ticks, and at once on a successful completion.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            code_ff <= `CODE_ZERO;
        else if (state_ff == rep_progress && !nxt_is_error &&
                 start_seen_ff && at_cylinder_zero)
            code_ff <= `CODE_ZERO;
        else if (state_ff == rep_progress && !nxt_is_error && seek_done)
            code_ff <= dest_ff[`CYL_CODE_MSB:`CYL_CODE_LSB];
        else if (tick && state_ff != rep_error)
            code_ff <= nxt_code;
        else if (tick && nxt_is_error)
            code_ff <= nxt_code;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            on_track_ff <= 1'b0;
        else if (tick && nxt_is_error)
            on_track_ff <= 1'b0;
        else if (state_ff == rep_progress && !nxt_is_error && seek_done)
            on_track_ff <= 1'b1;
        else if (seek_start)
            on_track_ff <= 1'b0;
    end

    assign status_code = code_ff;
    assign on_track    = on_track_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    self_test_code_a: assert property (
        self_test_fail ##1 1 ##[0:130] tick |=> status_code == `CODE_SELF_TEST)
        else $error("self-test failure not reported");

    on_track_ok_a: assert property (
        $rose(on_track) |-> state_ff == rep_destination)
        else $error("on-track raised without success");

    dest_code_a: assert property (
        $rose(on_track) |-> status_code == code_t'(dest_ff >> `CYL_CODE_LSB))
        else $error("destination code wrong");

    stable_code_a: assert property (
        !tick && !seek_done && !at_cylinder_zero |=> $stable(status_code))
        else $error("code changed without a commit");

    error_hold_a: assert property (
        state_ff == rep_error && !error_clear |=> state_ff == rep_error)
        else $error("error released without clear");

    dest_hold_a: assert property (
        state_ff == rep_destination && !seek_start && !pend_valid_ff
        && !self_fail_ff |=> state_ff == rep_destination)
        else $error("destination dropped early");

    bad_cyl_a: assert property (
        bad_cyl && !fault_prior |=> pend_err_ff == `CODE_BAD_CYL)
        else $error("illegal cylinder code wrong");

    error_track_a: assert property (
        state_ff == rep_error |-> !on_track)
        else $error("on-track high during error");

endmodule // servo_status_code_reporter
`default_nettype wire

// file: shared/status_defs.svh
`ifndef STATUS_DEFS_SVH
`define STATUS_DEFS_SVH

// ----------------------------------------------------------------------
// Status code values driven onto the test jack
// ----------------------------------------------------------------------
`define CODE_ZERO          8'h00
`define CODE_UNLOAD        8'h01
`define CODE_BRAKE         8'h02
`define CODE_STOPPED       8'h03
`define CODE_NO_PACK       8'h04
`define CODE_DOOR_LOCKED   8'h05
`define CODE_DOOR_NOLOCK   8'h06
`define CODE_HEADS_OUT     8'h07
`define CODE_STARTING      8'h08
`define CODE_SPIN_BASE     8'h09
`define CODE_SPIN_LAST     8'h0f
`define CODE_SPEED_LOSS    8'h10
`define CODE_RECOVERY_BIAS 8'h10
`define CODE_LOAD_BASE     8'h20
`define CODE_LOAD_RETRY    8'h28
`define CODE_RETRY_FIRST   8'h22
`define CODE_RETRY_LAST    8'h27
`define CODE_RTZ_BASE      8'h30
`define CODE_GUARD_BASE    8'h40
`define CODE_SEEK_TIMEOUT  8'h46
`define CODE_ONTRK_BASE    8'h47
`define CODE_OFF_TRACK     8'h4b
`define CODE_LOST_DEMOD    8'h4c
`define CODE_BAD_CYL       8'h4d
`define CODE_VOLT_FAULT    8'h4e
`define CODE_RESET_BASE    8'h50
`define CODE_FAN_MANY      8'h5b
`define CODE_FAN           8'h5c
`define CODE_FIRST_SEEK    8'h5d
`define CODE_DEMOD_UNLOAD  8'h5e
`define CODE_ADAPTER       8'h5f
`define CODE_PRE_FAULT     8'h80
`define CODE_SPEED_RECOV   8'h90
`define CODE_SELF_TEST     8'hff
`define CODE_PRE_BIAS      8'h80

// ----------------------------------------------------------------------
// Cylinder address layout and limits
// ----------------------------------------------------------------------
`define CYL_WIDTH          10
`define CYL_CODE_MSB       9
`define CYL_CODE_LSB       2
`define CYL_MAX            10'd822
`define FAN_FAULT_LIMIT    4'd10

// ----------------------------------------------------------------------
// Re-evaluation period of the status scan, set in ns and counted in cycles
// ----------------------------------------------------------------------
`define SCAN_PERIOD_NS     1000
`define CLOCK_PERIOD_NS    8
`define SCAN_CYCLES        (`SCAN_PERIOD_NS / `CLOCK_PERIOD_NS)
`define SCAN_CNT_WIDTH     8

`endif

// file: shared/status_pkg.sv
package status_pkg;

    // Servo sequence phase reported by the controlling processor.
    typedef enum logic [3:0]
    {
        phase_idle,
        phase_stop,
        phase_start,
        phase_load,
        phase_rtz,
        phase_seek,
        phase_on_track,
        phase_reset_recov
    } phase_e;

    // Guard band context in which a band was hit.
    typedef enum logic [1:0]
    {
        ctx_seek,
        ctx_routine,
        ctx_steady
    } guard_ctx_e;

    // Reporter state: what the held code means.
    typedef enum logic [1:0]
    {
        rep_progress,
        rep_destination,
        rep_error
    } rep_state_e;

    typedef logic [7:0] code_t;

endpackage

// file: verilog/scan_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_defs.svh"

// Periodic enable that paces re-evaluation of the servo status.
module scan_tick
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Enable pulse
    output logic      tick
);

    logic [`SCAN_CNT_WIDTH-1:0] count_ff;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // Free-running count; tick pulses one cycle every scan period.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            count_ff <= '0;
        else if (count_ff == `SCAN_CNT_WIDTH'(`SCAN_CYCLES - 1))
            count_ff <= '0;
        else
            count_ff <= count_ff + 1'b1;
    end

    assign tick = (count_ff == `SCAN_CNT_WIDTH'(`SCAN_CYCLES - 1));

endmodule // scan_tick
`default_nettype wire

// file: verilog/fan_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_defs.svh"

// Counts fan fault events and flags when the count passes the limit.
module fan_counter
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Events
    input  wire logic fan_fault,
    input  wire logic clear,
    // Result
    output logic      too_many
);

    logic [3:0] count_ff;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Saturates one above the limit so it never wraps back to quiet.
    // A fault in the clear cycle still counts, except when the count is already saturated.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            count_ff <= 4'h0;
        else if (fan_fault && count_ff <= `FAN_FAULT_LIMIT)
            count_ff <= (clear ? 4'h0 : count_ff) + 4'h1;
        else if (clear)
            count_ff <= 4'h0;
    end

    assign too_many = (count_ff > `FAN_FAULT_LIMIT);

endmodule // fan_counter
`default_nettype wire

// file: tb/status_display_board.sv
`timescale 1ns/1ps
`default_nettype none

// Display board on the test jack: it latches the two digits it shows.
module status_display_board
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // Test jack
    input  wire logic [7:0] status_code,
    input  wire logic       on_track,
    // Shown digits
    output logic [7:0]      shown,
    output logic            shown_on_track
);
    // The board just samples the jack; it never talks back.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            shown <= 8'h00;
            shown_on_track <= 1'b0;
        end
        else
        begin
            shown <= status_code;
            shown_on_track <= on_track;
        end
    end
endmodule // status_display_board
`default_nettype wire

// file: tb/tb_servo_status_code_reporter.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_defs.svh"

module tb_servo_status_code_reporter;
    import status_pkg::*;
    typedef struct packed {phase_e ph; logic [3:0] ix; logic rl; logic pr;
        guard_ctx_e cx; logic ou; code_t ex;} row_s;
    logic clock = 0, reset = 1, hu = 0, mb = 0, ms = 0, sp = 0, sr = 0;
    logic ss = 0, sd = 0, az = 0, fv = 0, rl = 0, pr = 0, ou = 0, fb = 0;
    logic sl = 0, ff = 0, st = 0, ec = 0;
    logic [9:0] cyl = 10'h000;
    logic [3:0] ix = 4'h0;
    phase_e ph = phase_idle;
    guard_ctx_e cx = ctx_seek;
    logic [7:0] code, shown;
    logic trk, shown_trk;
    int bad_count = 0, tests_run = 0, cyc = 0;
    row_s rows [14] = '{
        '{phase_start, 4'h0, 0, 0, ctx_seek, 0, 8'h09},
        '{phase_start, 4'h6, 0, 0, ctx_seek, 0, 8'h0f},
        '{phase_load, 4'h0, 0, 0, ctx_seek, 0, 8'h20},
        '{phase_load, 4'h7, 1, 0, ctx_seek, 0, 8'h2d},
        '{phase_load, 4'h0, 0, 1, ctx_seek, 0, 8'ha0},
        '{phase_rtz, 4'h9, 0, 0, ctx_seek, 0, 8'h39},
        '{phase_rtz, 4'h9, 0, 1, ctx_seek, 0, 8'hb9},
        '{phase_seek, 4'h0, 0, 0, ctx_seek, 0, 8'h46},
        '{phase_seek, 4'h1, 0, 0, ctx_steady, 1, 8'h45},
        '{phase_on_track, 4'h3, 0, 0, ctx_seek, 0, 8'h4a},
        '{phase_on_track, 4'h6, 0, 0, ctx_seek, 0, 8'h4e},
        '{phase_reset_recov, 4'h3, 0, 0, ctx_seek, 0, 8'h53},
        '{phase_reset_recov, 4'h6, 0, 0, ctx_seek, 0, 8'h5f},
        '{phase_idle, 4'h0, 0, 0, ctx_seek, 0, 8'h04}};

    servo_status_code_reporter i_servo_status_code_reporter (.clock(clock),
        .reset(reset), .phase(ph), .heads_unloading(hu), .motor_braking(mb),
        .motor_stopped(ms), .start_in_progress(sp), .speed_recovery(sr),
        .seek_start(ss), .seek_cylinder(cyl), .seek_done(sd),
        .at_cylinder_zero(az), .fault_valid(fv), .fault_index(ix),
        .fault_retry_limit(rl), .fault_prior(pr), .guard_ctx(cx),
        .guard_outer(ou), .fault_before_seek(fb), .speed_loss_recovered(sl),
        .fan_fault(ff), .self_test_fail(st), .error_clear(ec),
        .status_code(code), .on_track(trk));
    status_display_board i_status_display_board (.clock(clock), .reset(reset),
        .status_code(code), .on_track(trk), .shown(shown),
        .shown_on_track(shown_trk));

    // Clock of 8 ns; a cycle ceiling cuts a hang short.
    initial
    begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    // Inputs move 1 ns after the rising edge.
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Commit waits for the next scan tick, so allow a full period and more.
    task automatic wait_code(logic [7:0] exp);
        for (int i = 0; i < 140 && code !== exp; i++) step(1);
        check(code, exp);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        step(1);
        s = 0;
    endtask
    task automatic finish_test();
        $display("tests %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        step(20);
        check(code, 8'h00);
        reset = 0;
        step(1);
        foreach (rows[i])
        begin
            {ph, ix, rl, pr, cx, ou} = {rows[i].ph, rows[i].ix, rows[i].rl,
                rows[i].pr, rows[i].cx, rows[i].ou};
            pulse(fv);
            wait_code(rows[i].ex);
            check({7'h00, trk}, 8'h00);
            pulse(ec);
            $display("row %0d done", i);
        end
        // A seek to 0x334 shows CD with on-track one edge after done.
        ph = phase_seek;
        cyl = 10'h334;
        pulse(ss);
        step(3);
        pulse(sd);
        check(code, 8'hcd);
        check({7'h00, trk}, 8'h01);
        step(200);
        check(shown, 8'hcd);
        check({7'h00, shown_trk}, 8'h01);
        cyl = 10'd823;
        pulse(ss);
        wait_code(8'h4d);
        pulse(ec);
        pulse(fb);
        wait_code(8'h80);
        pulse(ec);
        pulse(sl);
        wait_code(8'h90);
        pulse(ec);
        // Separate pulses, so the strobe never rises in the edge it falls.
        repeat (11)
        begin
            pulse(ff);
            step(1);
        end
        wait_code(8'h5b);
        pulse(ec);
        pulse(st);
        wait_code(8'hff);
        pulse(ec);
        step(200);
        check(code, 8'hff);
        $display("hand tests done");
        reset = 1;
        step(2);
        check(code, 8'h00);
        // Reset alone lifts the sticky self-test report.
        reset = 0;
        step(130);
        check(code, 8'h00);
        check({7'h00, trk}, 8'h00);
        hu = 1;
        wait_code(8'h01);
        {hu, mb} = 2'b01;
        wait_code(8'h02);
        {mb, ms} = 2'b01;
        wait_code(8'h03);
        {ms, sp, sr} = 3'b011;
        wait_code(8'h18);
        sr = 0;
        wait_code(8'h08);
        {sp, az} = 2'b01;
        step(1);
        check(code, 8'h00);
        check({7'h00, trk}, 8'h00);
        $display("progress tests done");
        finish_test();
    end
endmodule // tb_servo_status_code_reporter
`default_nettype wire
